// *** src/lgp_pkg.sv ***
// Package for the LCD-muxed general-purpose port: register map, fields, types
// ==========================================================================
// Contract
// - One eight-pin bidirectional port, matching registers
// - Direction bit 0 drives latch, 1 reads
// - All pins inputs after any reset
// - Global pull-up enable at pad config bit 7
// - Direction-0 pins have pull-up forced off; pins 0 and 5 keep it when they drive with direction 1
// - Pull-up enable resets cleared
// - Segment enable bit takes pin entirely
// - Pin 0 carries charge pulse, direction ignored
// - Pin 1 feeds timer clock and gate
// - Pin 4 outputs serial data when direction 0
// - Pin 5 input feeds serial data in
// - Pin 6 drives or receives SPI clock
// - Pin 6 drives I2C clock in I2C mode; code drives it only with direction 0
// - Pin 7 supplies slave-select when input
// - Open-drain bit makes SPI outputs open-drain
// - Port reads use Schmitt input path
package lgp_pkg;

  // ==========================================================================
  // Register map (word offsets on the plain register port)
  localparam int          LGP_ADDR_W         = 4;
  localparam logic [3:0]  LGP_OFF_PIN_LEVEL  = 4'h0;
  localparam logic [3:0]  LGP_OFF_LATCH      = 4'h1;
  localparam logic [3:0]  LGP_OFF_DIRECTION  = 4'h2;
  localparam logic [3:0]  LGP_OFF_SEGMENT    = 4'h3;
  localparam logic [3:0]  LGP_OFF_PAD_CONFIG = 4'h4;
  localparam logic [3:0]  LGP_OFF_OPEN_DRAIN = 4'h5;
  localparam logic [3:0]  LGP_OFF_PERIPH     = 4'h6;

  // ==========================================================================
  // Field positions
  localparam int          LGP_PAD_PULLUP_BIT = 7;
  localparam int          LGP_OD_SERIAL_BIT  = 0;
  localparam int          LGP_PER_CHARGE_BIT = 0;
  localparam int          LGP_PER_I2C_BIT    = 1;

  // ==========================================================================
  // Reset values
  localparam logic [7:0]  LGP_RST_DIRECTION  = 8'hFF;
  localparam logic [7:0]  LGP_RST_LATCH      = 8'h00;
  localparam logic [7:0]  LGP_RST_SEGMENT    = 8'h00;
  localparam logic [7:0]  LGP_RST_PAD_CONFIG = 8'h00;
  localparam logic [7:0]  LGP_RST_OPEN_DRAIN = 8'h00;
  localparam logic [7:0]  LGP_RST_PERIPH     = 8'h00;
  localparam logic [7:0]  LGP_UNMAPPED_READ  = 8'h00;

  // ==========================================================================
  // Pin numbers of the shared functions
  localparam int          LGP_PIN_CHARGE     = 0;
  localparam int          LGP_PIN_TIMER      = 1;
  localparam int          LGP_PIN_SDO        = 4;
  localparam int          LGP_PIN_SDI        = 5;
  localparam int          LGP_PIN_SCK        = 6;
  localparam int          LGP_PIN_SELECT     = 7;

  // Peripheral signals arriving from the serial and charge-time units
  typedef struct packed {
    logic charge_pulse_out;
    logic serial_b_data_out;
    logic serial_b_data_out_en;
    logic serial_b_spi_clock;
    logic serial_b_i2c_data;
    logic serial_b_i2c_data_oe;
  } lgp_periph_out_t;

  // Pin levels handed to the peripherals
  typedef struct packed {
    logic timer_five_clock_in;
    logic timer_seven_gate_in;
    logic serial_b_data_in;
    logic serial_b_i2c_data;
    logic serial_b_clock_in;
    logic serial_b_select;
  } lgp_periph_in_t;

endpackage : lgp_pkg

// *** src/lgp_port.sv ***
// Eight-pin port with segment override, peripheral muxing and register slave
`timescale 1ns/1ps
module lgp_port
  import lgp_pkg::*;
#(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic                  i_clk,
  input  wire logic                  i_reset,
  // Register port
  input  wire logic [LGP_ADDR_W-1:0] i_addr,
  input  wire logic [7:0]            i_wdata,
  input  wire logic                  i_wr,
  input  wire logic                  i_rd,
  output logic      [7:0]            o_rdata,
  // Pins
  input  wire logic [WIDTH-1:0]      i_pin,
  output logic      [WIDTH-1:0]      o_pin,
  output logic      [WIDTH-1:0]      o_pin_oe,
  output logic      [WIDTH-1:0]      o_pullup_on,
  output logic      [WIDTH-1:0]      o_segment_output,
  // Peripherals
  input  wire lgp_periph_out_t       i_periph,
  output lgp_periph_in_t             o_periph
);

  // Pin map is fixed at eight pins
  if (WIDTH != 8) begin : g_width_check
    $error("lgp_port: WIDTH must be 8");
  end

  // ==========================================================================
  // Registers
  logic [WIDTH-1:0] latch_q;
  logic [WIDTH-1:0] dir_q;
  logic [WIDTH-1:0] seg_q;
  logic [7:0]       pad_q;
  logic [7:0]       od_q;
  logic [7:0]       per_q;
  logic [WIDTH-1:0] pin_sync_q;

  function automatic logic hit(input logic [LGP_ADDR_W-1:0] off);
    hit = i_wr && (i_addr == off);
  endfunction

  // Latch written through either the latch or the pin-level address
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      latch_q <= LGP_RST_LATCH;
    end else if (hit(LGP_OFF_LATCH) || hit(LGP_OFF_PIN_LEVEL)) begin
      latch_q <= i_wdata;
    end
  end

  // Direction: all ones at reset so nothing drives
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      dir_q <= LGP_RST_DIRECTION;
    end else if (hit(LGP_OFF_DIRECTION)) begin
      dir_q <= i_wdata;
    end
  end

  // Segment enables
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      seg_q <= LGP_RST_SEGMENT;
    end else if (hit(LGP_OFF_SEGMENT)) begin
      seg_q <= i_wdata;
    end
  end

  // Pad config: only the pull-up enable is kept here, others read zero
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      pad_q <= LGP_RST_PAD_CONFIG;
    end else if (hit(LGP_OFF_PAD_CONFIG)) begin
      pad_q <= i_wdata & (8'h01 << LGP_PAD_PULLUP_BIT);
    end
  end

  // Open-drain control, serial bit only
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      od_q <= LGP_RST_OPEN_DRAIN;
    end else if (hit(LGP_OFF_OPEN_DRAIN)) begin
      od_q <= i_wdata & (8'h01 << LGP_OD_SERIAL_BIT);
    end
  end

  // Peripheral selects: charge pulse on pin 0, serial in I2C mode
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      per_q <= LGP_RST_PERIPH;
    end else if (hit(LGP_OFF_PERIPH)) begin
      per_q <= i_wdata & 8'h03;
    end
  end

  // Schmitt-buffered sample for port reads; inputs already synchronous
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      pin_sync_q <= '0;
    end else begin
      pin_sync_q <= i_pin;
    end
  end

  // ==========================================================================
  // Read port: data stand the cycle after the strobe only
  always_ff @(posedge i_clk) begin
    if (i_reset || !i_rd) begin
      o_rdata <= 8'h00;
    end else begin
      case (i_addr)
        LGP_OFF_PIN_LEVEL:  o_rdata <= pin_sync_q;
        LGP_OFF_LATCH:      o_rdata <= latch_q;
        LGP_OFF_DIRECTION:  o_rdata <= dir_q;
        LGP_OFF_SEGMENT:    o_rdata <= seg_q;
        LGP_OFF_PAD_CONFIG: o_rdata <= pad_q;
        LGP_OFF_OPEN_DRAIN: o_rdata <= od_q;
        LGP_OFF_PERIPH:     o_rdata <= per_q;
        default:            o_rdata <= LGP_UNMAPPED_READ;
      endcase
    end
  end

  // ==========================================================================
  // Pin ownership, combinational next values
  logic [WIDTH-1:0] pin_d;
  logic [WIDTH-1:0] oe_d;
  logic             i2c_mode;
  logic             od_en;

  assign i2c_mode = per_q[LGP_PER_I2C_BIT];
  assign od_en    = od_q[LGP_OD_SERIAL_BIT];

  // Peripheral overrides first, then segment wipes everything
  always_comb begin
    pin_d = latch_q;
    oe_d  = ~dir_q;
    if (per_q[LGP_PER_CHARGE_BIT]) begin
      pin_d[LGP_PIN_CHARGE] = i_periph.charge_pulse_out;
      oe_d[LGP_PIN_CHARGE]  = 1'b1;
    end
    if (!dir_q[LGP_PIN_SDO] && !i2c_mode && i_periph.serial_b_data_out_en) begin
      pin_d[LGP_PIN_SDO] = i_periph.serial_b_data_out;
      // Open drain: drive only the low level
      oe_d[LGP_PIN_SDO]  = !od_en || !i_periph.serial_b_data_out;
    end
    if (i2c_mode && i_periph.serial_b_i2c_data_oe) begin
      // I2C data is always open drain
      pin_d[LGP_PIN_SDI] = 1'b0;
      oe_d[LGP_PIN_SDI]  = !i_periph.serial_b_i2c_data;
    end
    if (!dir_q[LGP_PIN_SCK]) begin
      pin_d[LGP_PIN_SCK] = i_periph.serial_b_spi_clock;
      if (i2c_mode || od_en) begin
        oe_d[LGP_PIN_SCK] = !i_periph.serial_b_spi_clock;
      end
    end
    oe_d  = oe_d & ~seg_q;
    pin_d = pin_d & ~seg_q;
  end

  // Registered pin drivers
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_pin            <= '0;
      o_pin_oe         <= '0;
      o_pullup_on      <= '0;
      o_segment_output <= '0;
    end else begin
      o_pin            <= pin_d;
      o_pin_oe         <= oe_d;
      o_pullup_on      <= {WIDTH{pad_q[LGP_PAD_PULLUP_BIT]}} & dir_q & ~seg_q;
      o_segment_output <= seg_q;
    end
  end

  // Peripheral inputs, blocked while the segment owns the pin
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_periph <= '0;
    end else begin
      o_periph.timer_five_clock_in <= i_pin[LGP_PIN_TIMER] & ~seg_q[LGP_PIN_TIMER];
      o_periph.timer_seven_gate_in <= i_pin[LGP_PIN_TIMER] & ~seg_q[LGP_PIN_TIMER];
      o_periph.serial_b_data_in    <= i_pin[LGP_PIN_SDI] & dir_q[LGP_PIN_SDI]
                                      & ~seg_q[LGP_PIN_SDI];
      o_periph.serial_b_i2c_data   <= i_pin[LGP_PIN_SDI] & ~seg_q[LGP_PIN_SDI];
      o_periph.serial_b_clock_in   <= i_pin[LGP_PIN_SCK] & dir_q[LGP_PIN_SCK]
                                      & ~seg_q[LGP_PIN_SCK];
      // Select idles high (inactive) when not routed
      o_periph.serial_b_select     <= ~(dir_q[LGP_PIN_SELECT] & ~seg_q[LGP_PIN_SELECT])
                                      | i_pin[LGP_PIN_SELECT];
    end
  end

endmodule // lgp_port

// *** tb/lgp_port_monitor.sv ***
// Checker for the port's pin and register outputs
`timescale 1ns/1ps
module lgp_port_monitor
  import lgp_pkg::*;
(
  // Clock, reset and register port
  input wire logic            i_clk,
  input wire logic            i_reset,
  input wire logic [3:0]      i_addr,
  input wire logic            i_rd,
  input wire logic [7:0]      o_rdata,
  // Pins and peripherals
  input wire logic [7:0]      i_pin,
  input wire logic [7:0]      o_pin_oe,
  input wire logic [7:0]      o_pullup_on,
  input wire logic [7:0]      o_segment_output,
  input wire lgp_periph_in_t  o_periph
);
  // ==========================================================================
  // Assertions
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  // Pins 0 and 5 may drive as inputs, so they stay out of the pull-up mask
  seg_no_drive_a: assert property ((o_segment_output & o_pin_oe) == 8'h00)
    else $error("segment pin driven");
  pull_off_out_a: assert property ((o_pullup_on & o_pin_oe & 8'hDE) == 8'h00)
    else $error("pull-up on driven pin");
  seg_no_pull_a: assert property ((o_segment_output & o_pullup_on) == 8'h00)
    else $error("pull-up on segment pin");
  reset_drive_a: assert property ($past(i_reset) |-> o_pin_oe == 8'h00)
    else $error("pin driven after reset");
  reset_pull_a: assert property ($past(i_reset) |-> o_pullup_on == 8'h00)
    else $error("pull-up on after reset");
  rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data outside read");
  pin_read_a: assert property ($past(i_rd) && $past(i_addr) == LGP_OFF_PIN_LEVEL
    && o_segment_output == 8'h00 |-> o_rdata == $past(i_pin, 2)) else $error("pin read");
  timer_pair_a: assert property (o_periph.timer_five_clock_in == o_periph.timer_seven_gate_in)
    else $error("timer inputs differ");
endmodule // lgp_port_monitor

bind lgp_port lgp_port_monitor lgp_port_monitor_inst (.i_clk, .i_reset, .i_addr, .i_rd,
  .o_rdata, .i_pin, .o_pin_oe, .o_pullup_on, .o_segment_output, .o_periph);

// *** tb/lgp_board_model.sv ***
// Board-side model resolving each pin level
`timescale 1ns/1ps
module lgp_board_model (
  // Clock and port side
  input  wire logic       i_clk,
  input  wire logic [7:0] i_pin_out,
  input  wire logic [7:0] i_pin_oe,
  input  wire logic [7:0] i_pullup_on,
  // Board drive
  input  wire logic [7:0] i_ext_val,
  input  wire logic [7:0] i_ext_en,
  output logic      [7:0] o_level
);
  // ==========================================================================
  // Undriven pins wander so a stale level never reads as valid
  logic float_q;
  initial float_q = 1'b0;
  always @(posedge i_clk) float_q <= ~float_q;
  // Port drive wins, then board, then weak pull-up
  always_comb begin
    for (int n = 0; n < 8; n++) begin
      if (i_pin_oe[n]) o_level[n] = i_pin_out[n];
      else if (i_ext_en[n]) o_level[n] = i_ext_val[n];
      else if (i_pullup_on[n]) o_level[n] = 1'b1;
      else o_level[n] = float_q;
    end
  end
endmodule // lgp_board_model

// *** tb/lgp_port_tb_top.sv ***
// Self-checking bench for the muxed port
`timescale 1ns/1ps
module lgp_port_tb_top
  import lgp_pkg::*;
;
  // ==========================================================================
  // Stimulus and observed signals
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, ext_val = 8'h00, ext_en = 8'h00;
  logic [7:0] rdata, pin_in, pin_out, pin_oe, pull, seg;
  lgp_periph_out_t per_o = '0;
  lgp_periph_in_t  per_i;
  int miscompares = 0, compares = 0;
  initial forever #2.5 clk = ~clk;
  lgp_port lgp_port_inst (.i_clk(clk), .i_reset(rst), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_pin(pin_in), .o_pin(pin_out), .o_pin_oe(pin_oe),
    .o_pullup_on(pull), .o_segment_output(seg), .i_periph(per_o), .o_periph(per_i));
  lgp_board_model lgp_board_model_inst (.i_clk(clk), .i_pin_out(pin_out), .i_pin_oe(pin_oe),
    .i_pullup_on(pull), .i_ext_val(ext_val), .i_ext_en(ext_en), .o_level(pin_in));
  // ==========================================================================
  // Shared bus and compare tasks
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wrr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rdc(input logic [3:0] a, input logic [7:0] exp, input string nm);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(nm, exp, rdata);
  endtask
  task automatic settle;
    repeat (4) @(posedge clk);
    #1;
  endtask
  task automatic tally_and_finish;
    $display("Compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_reset;
    rdc(LGP_OFF_DIRECTION, 8'hFF, "direction");
    rdc(LGP_OFF_PAD_CONFIG, 8'h00, "pad");
    rdc(4'hF, 8'h00, "unmapped");
    chk("oe", 8'h00, pin_oe);
  endtask
  task automatic t_drive;
    wrr(LGP_OFF_LATCH, 8'hA5);
    wrr(LGP_OFF_DIRECTION, 8'h00);
    settle;
    chk("pin_out", 8'hA5, pin_out);
    chk("oe", 8'hFF, pin_oe);
    wrr(LGP_OFF_PIN_LEVEL, 8'h3C);
    rdc(LGP_OFF_LATCH, 8'h3C, "latch");
  endtask
  task automatic t_pull;
    wrr(LGP_OFF_PAD_CONFIG, 8'hFF);
    wrr(LGP_OFF_DIRECTION, 8'h0F);
    ext_en <= 8'h06;
    ext_val <= 8'h06;
    settle;
    chk("pullup", 8'h0F, pull);
    rdc(LGP_OFF_PAD_CONFIG, 8'h80, "pad");
    rdc(LGP_OFF_PIN_LEVEL, 8'h3F, "level");
    chk("timer", 8'h01, {7'h00, per_i.timer_five_clock_in});
    chk("sda_sck", 8'h02, {6'h00, per_i.serial_b_i2c_data, per_i.serial_b_clock_in});
    wrr(LGP_OFF_PAD_CONFIG, 8'h00);
    settle;
    chk("pullup", 8'h00, pull);
  endtask
  task automatic t_seg;
    wrr(LGP_OFF_DIRECTION, 8'h00);
    wrr(LGP_OFF_SEGMENT, 8'h81);
    settle;
    chk("oe", 8'h7E, pin_oe);
    chk("segment", 8'h81, seg);
    wrr(LGP_OFF_SEGMENT, 8'h00);
  endtask
  // Shared functions: charge pulse, SPI out, open-drain, I2C clock, inputs
  task automatic t_periph;
    wrr(LGP_OFF_PERIPH, 8'h01);
    wrr(LGP_OFF_DIRECTION, 8'hAF);
    per_o <= 6'b101101;
    ext_en <= 8'hA6;
    ext_val <= 8'h26;
    settle;
    chk("charge", 8'h03, {6'h00, pin_oe[0], pin_out[0]});
    chk("spi", 8'h40, pin_out & 8'h50);
    chk("sdi_ss", 8'h02, {6'h00, per_i.serial_b_data_in, per_i.serial_b_select});
    wrr(LGP_OFF_OPEN_DRAIN, 8'h01);
    settle;
    chk("od", 8'h00, {7'h00, pin_oe[6]});
    wrr(LGP_OFF_PERIPH, 8'h02);
    per_o <= 6'b000000;
    settle;
    chk("i2c_clk", 8'h02, {6'h00, pin_oe[6], pin_out[6]});
  endtask
  // ==========================================================================
  // Main sequence and watchdog
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_drive;
    t_pull;
    t_seg;
    t_periph;
    tally_and_finish;
  end
  initial begin
    #20000;
    miscompares++;
    tally_and_finish;
  end
endmodule // lgp_port_tb_top
